// File: src/agc_cfg_pkg.sv
// constants, register layout and carriers of the gain control block
package agc_cfg_pkg;
  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [5:0] GAIN_LIMIT_ADDR = 6'h1B;
  localparam logic [5:0] STRATEGY_ADDR = 6'h1C;
  localparam int DIG_CEIL_LSB = 6;
  localparam int FE_CEIL_LSB = 3;
  localparam int SETPOINT_LSB = 0;
  localparam int ORDER_BIT = 6;
  localparam int REL_THR_LSB = 4;
  localparam logic [1:0] DIG_CEIL_RST = 2'h0;
  localparam logic [2:0] FE_CEIL_RST = 3'h0;
  localparam logic [2:0] SETPOINT_RST = 3'h3;
  localparam logic ORDER_RST = 1'b1;
  localparam logic [1:0] REL_THR_RST = 2'h0;
  // ----------------------------------------------------------------
  // serial port framing
  // ----------------------------------------------------------------
  localparam int HDR_RW_BIT = 7;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [4:0] FRAME_DONE = 5'h10;
  // ----------------------------------------------------------------
  // gain steps, in dB of amplitude where noted
  // ----------------------------------------------------------------
  localparam logic [2:0] DIG_TOP = 3'h7;
  localparam logic [2:0] STAGE_RED_MAX = 3'h7;
  localparam logic [7:0] SETPOINT_DB [8] = '{8'h18, 8'h1B, 8'h1E, 8'h21,
                                             8'h24, 8'h26, 8'h28, 8'h2A};
  localparam logic [7:0] REL_THR_DB [4] = '{8'h00, 8'h06, 8'h0A, 8'h0E};

  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [2:0] dig;
    logic [2:0] stage1_red;
    logic [2:0] stage2_red;
  } gain_s;
endpackage : agc_cfg_pkg

// File: src/reg_serial_port.sv
// serial register port: header byte then one data byte, msb first
module reg_serial_port (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output agc_cfg_pkg::reg_req_s req,
  output logic [5:0] rd_addr,
  input wire logic [7:0] rdata
);
  logic sclk_q_ff, nxt_sclk_q;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] hdr_ff, nxt_hdr;
  logic [7:0] out_ff, nxt_out;
  logic load_ff, nxt_load;
  agc_cfg_pkg::reg_req_s req_ff, nxt_req;
  logic rise, fall;

  assign rise = sclk & ~sclk_q_ff;
  assign fall = ~sclk & sclk_q_ff;
  assign rd_addr = hdr_ff[5:0];
  assign req = req_ff;
  assign miso = out_ff[7];
  assign miso_oe = ~csn;

  // ----------------------------------------------------------------
  // bit counter, shifters and write strobe
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sclk_q = sclk;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_hdr = hdr_ff;
    nxt_out = out_ff;
    nxt_load = 1'b0;
    nxt_req = '0;
    if (csn) begin
      nxt_cnt = '0;
    end else if (rise && cnt_ff != agc_cfg_pkg::FRAME_DONE) begin
      nxt_shift = {shift_ff[6:0], mosi};
      nxt_cnt = cnt_ff + 5'h01;
      if (cnt_ff == agc_cfg_pkg::HDR_LAST) begin
        nxt_hdr = nxt_shift;
        nxt_load = 1'b1;
      end
      if (cnt_ff == agc_cfg_pkg::DATA_LAST &&
          !hdr_ff[agc_cfg_pkg::HDR_RW_BIT]) begin
        nxt_req.wr = 1'b1;
        nxt_req.addr = hdr_ff[5:0];
        nxt_req.wdata = nxt_shift;
      end
    end else if (fall && cnt_ff > agc_cfg_pkg::DATA_FIRST &&
                 cnt_ff != agc_cfg_pkg::FRAME_DONE) begin
      nxt_out = {out_ff[6:0], 1'b0};
    end
    if (load_ff) begin
      nxt_out = rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_q_ff <= 1'b0;
      cnt_ff <= '0;
      shift_ff <= '0;
      hdr_ff <= '0;
      out_ff <= '0;
      load_ff <= 1'b0;
      req_ff <= '0;
    end else begin
      sclk_q_ff <= nxt_sclk_q;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      hdr_ff <= nxt_hdr;
      out_ff <= nxt_out;
      load_ff <= nxt_load;
      req_ff <= nxt_req;
    end
  end
endmodule : reg_serial_port

// File: src/agc_gain_limit_config.sv
// gain control configuration registers and the gain stepping loop

// Notes on behaviour
// - the two-bit digital gain ceiling, reset 0, removes 0 to 3 top steps.
// - the three-bit front-end ceiling, reset 0, caps combined stage gain.
// - the three-bit setpoint, reset 3, picks 24..42 dB target amplitude.
// - the order bit, reset 1, lowers stage one first, else stage two.
// - the two-bit relative carrier threshold field resets to zero.
// - relative threshold codes 0..3 mean off, 6 dB, 10 dB and 14 dB rise.
module agc_gain_limit_config (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [7:0] filt_amp,
  input wire logic amp_valid,
  input wire logic [7:0] rssi,
  input wire logic rssi_valid,
  output agc_cfg_pkg::gain_s gain,
  output logic carrier_sense
);
  agc_cfg_pkg::reg_req_s req;
  logic [5:0] rd_addr;
  logic [7:0] rdata;

  reg_serial_port u_port (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sclk(sclk),
    .csn(csn),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .req(req),
    .rd_addr(rd_addr),
    .rdata(rdata)
  );

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [1:0] dig_ceil_ff, nxt_dig_ceil;
  logic [2:0] fe_ceil_ff, nxt_fe_ceil;
  logic [2:0] setpoint_ff, nxt_setpoint;
  logic order_ff, nxt_order;
  logic [1:0] rel_thr_ff, nxt_rel_thr;

  always_comb begin
    nxt_dig_ceil = dig_ceil_ff;
    nxt_fe_ceil = fe_ceil_ff;
    nxt_setpoint = setpoint_ff;
    nxt_order = order_ff;
    nxt_rel_thr = rel_thr_ff;
    if (req.wr && req.addr == agc_cfg_pkg::GAIN_LIMIT_ADDR) begin
      nxt_dig_ceil = req.wdata[agc_cfg_pkg::DIG_CEIL_LSB +: 2];
      nxt_fe_ceil = req.wdata[agc_cfg_pkg::FE_CEIL_LSB +: 3];
      nxt_setpoint = req.wdata[agc_cfg_pkg::SETPOINT_LSB +: 3];
    end
    if (req.wr && req.addr == agc_cfg_pkg::STRATEGY_ADDR) begin
      nxt_order = req.wdata[agc_cfg_pkg::ORDER_BIT];
      nxt_rel_thr = req.wdata[agc_cfg_pkg::REL_THR_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dig_ceil_ff <= agc_cfg_pkg::DIG_CEIL_RST;
      fe_ceil_ff <= agc_cfg_pkg::FE_CEIL_RST;
      setpoint_ff <= agc_cfg_pkg::SETPOINT_RST;
      order_ff <= agc_cfg_pkg::ORDER_RST;
      rel_thr_ff <= agc_cfg_pkg::REL_THR_RST;
    end else begin
      dig_ceil_ff <= nxt_dig_ceil;
      fe_ceil_ff <= nxt_fe_ceil;
      setpoint_ff <= nxt_setpoint;
      order_ff <= nxt_order;
      rel_thr_ff <= nxt_rel_thr;
    end
  end

  // read mux; reserved bit and unimplemented low nibble read zero
  always_comb begin
    rdata = '0;
    case (rd_addr)
      agc_cfg_pkg::GAIN_LIMIT_ADDR: begin
        rdata[agc_cfg_pkg::DIG_CEIL_LSB +: 2] = dig_ceil_ff;
        rdata[agc_cfg_pkg::FE_CEIL_LSB +: 3] = fe_ceil_ff;
        rdata[agc_cfg_pkg::SETPOINT_LSB +: 3] = setpoint_ff;
      end
      agc_cfg_pkg::STRATEGY_ADDR: begin
        rdata[agc_cfg_pkg::ORDER_BIT] = order_ff;
        rdata[agc_cfg_pkg::REL_THR_LSB +: 2] = rel_thr_ff;
      end
      default: rdata = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // gain loop
  // ----------------------------------------------------------------
  function automatic logic [3:0] fe_total(input agc_cfg_pkg::gain_s g);
    fe_total = {1'b0, g.stage1_red} + {1'b0, g.stage2_red};
  endfunction : fe_total

  // one more step of front-end reduction in the selected order
  function automatic agc_cfg_pkg::gain_s fe_down(
    input agc_cfg_pkg::gain_s g, input logic stage1_first);
    fe_down = g;
    if (stage1_first) begin
      if (g.stage1_red != agc_cfg_pkg::STAGE_RED_MAX) begin
        fe_down.stage1_red = g.stage1_red + 3'h1;
      end else if (g.stage2_red != agc_cfg_pkg::STAGE_RED_MAX) begin
        fe_down.stage2_red = g.stage2_red + 3'h1;
      end
    end else begin
      if (g.stage2_red != agc_cfg_pkg::STAGE_RED_MAX) begin
        fe_down.stage2_red = g.stage2_red + 3'h1;
      end else if (g.stage1_red != agc_cfg_pkg::STAGE_RED_MAX) begin
        fe_down.stage1_red = g.stage1_red + 3'h1;
      end
    end
  endfunction : fe_down

  agc_cfg_pkg::gain_s gain_ff, nxt_gain;
  logic [2:0] dig_max;
  logic [7:0] target_db;

  assign dig_max = agc_cfg_pkg::DIG_TOP - {1'b0, dig_ceil_ff};
  assign target_db = agc_cfg_pkg::SETPOINT_DB[setpoint_ff];
  assign gain = gain_ff;

  always_comb begin
    nxt_gain = gain_ff;
    if (gain_ff.dig > dig_max) begin
      nxt_gain.dig = dig_max;
    end else if (fe_total(gain_ff) < {1'b0, fe_ceil_ff}) begin
      nxt_gain = fe_down(gain_ff, order_ff);
    end else if (amp_valid && filt_amp > target_db) begin
      if (gain_ff.dig != '0) begin
        nxt_gain.dig = gain_ff.dig - 3'h1;
      end else begin
        nxt_gain = fe_down(gain_ff, order_ff);
      end
    end else if (amp_valid && filt_amp < target_db) begin
      // raise in the reverse of the reduction order
      if (fe_total(gain_ff) > {1'b0, fe_ceil_ff}) begin
        if (order_ff ? gain_ff.stage2_red != '0
                     : gain_ff.stage1_red == '0) begin
          nxt_gain.stage2_red = gain_ff.stage2_red - 3'h1;
        end else begin
          nxt_gain.stage1_red = gain_ff.stage1_red - 3'h1;
        end
      end else if (gain_ff.dig < dig_max) begin
        nxt_gain.dig = gain_ff.dig + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gain_ff <= '0;
    end else begin
      gain_ff <= nxt_gain;
    end
  end

  // ----------------------------------------------------------------
  // relative carrier sense
  // ----------------------------------------------------------------
  logic [7:0] ref_ff, nxt_ref;
  logic ref_ok_ff, nxt_ref_ok;
  logic cs_ff, nxt_cs;
  logic [8:0] need;

  assign need = {1'b0, ref_ff} + {1'b0, agc_cfg_pkg::REL_THR_DB[rel_thr_ff]};
  assign carrier_sense = cs_ff;

  always_comb begin
    nxt_ref = ref_ff;
    nxt_ref_ok = ref_ok_ff;
    nxt_cs = cs_ff;
    if (rel_thr_ff == '0) begin
      nxt_cs = 1'b0;
      nxt_ref_ok = 1'b0;
    end else if (rssi_valid) begin
      if (!ref_ok_ff || rssi < ref_ff) begin
        nxt_ref = rssi;
        nxt_ref_ok = 1'b1;
      end
      nxt_cs = ref_ok_ff && {1'b0, rssi} >= need;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ref_ff <= '0;
      ref_ok_ff <= 1'b0;
      cs_ff <= 1'b0;
    end else begin
      ref_ff <= nxt_ref;
      ref_ok_ff <= nxt_ref_ok;
      cs_ff <= nxt_cs;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  dig_ceiling_a: assert property (
    $past(gain_ff.dig) <= $past(dig_max) |-> gain_ff.dig <= $past(dig_max))
    else $error("digital gain above its ceiling");
  dig_clamp_a: assert property (
    gain_ff.dig > dig_max |=> gain_ff.dig == $past(dig_max))
    else $error("digital gain not pulled to its ceiling");
  fe_ceiling_a: assert property (
    fe_total(gain_ff) >= {1'b0, fe_ceil_ff} && !req.wr
    |=> fe_total(gain_ff) >= {1'b0, $past(fe_ceil_ff)})
    else $error("front-end gain above its ceiling");
  setpoint_write_a: assert property (
    req.wr && req.addr == agc_cfg_pkg::GAIN_LIMIT_ADDR
    |=> setpoint_ff == $past(req.wdata[agc_cfg_pkg::SETPOINT_LSB +: 3]))
    else $error("setpoint not taken from write");
  order_first_a: assert property (
    order_ff && amp_valid && filt_amp > target_db && gain_ff.dig == '0 &&
    fe_total(gain_ff) >= {1'b0, fe_ceil_ff} && gain_ff.dig <= dig_max &&
    gain_ff.stage1_red != agc_cfg_pkg::STAGE_RED_MAX
    |=> gain_ff.stage1_red == $past(gain_ff.stage1_red) + 3'h1)
    else $error("stage one not reduced first");
  rel_thr_write_a: assert property (
    req.wr && req.addr == agc_cfg_pkg::STRATEGY_ADDR
    |=> rel_thr_ff == $past(req.wdata[agc_cfg_pkg::REL_THR_LSB +: 2]) &&
        order_ff == $past(req.wdata[agc_cfg_pkg::ORDER_BIT]))
    else $error("strategy register not updated");
  cs_off_a: assert property (
    rel_thr_ff == '0 |=> !carrier_sense)
    else $error("carrier sense with threshold disabled");
  reserved_zero_a: assert property (
    rd_addr == agc_cfg_pkg::STRATEGY_ADDR |-> rdata[7] == 1'b0)
    else $error("reserved bit reads nonzero");

  gain_drop_c: cover property (amp_valid && filt_amp > target_db ##1 1'b1);
  cs_rise_c: cover property (!carrier_sense ##1 carrier_sense);
  clamp_c: cover property (gain_ff.dig > dig_max);
endmodule : agc_gain_limit_config

// File: dv/test_agc_gain_limit_config.sv
// self-checking bench for the gain control configuration block
module test_agc_gain_limit_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, sclk, csn, mosi, amp_valid, rssi_valid;
  logic [7:0] filt_amp, rssi, rd;
  logic miso, miso_oe, carrier_sense;
  agc_cfg_pkg::gain_s gain;
  int failures = 0;
  int checks_done = 0;
  localparam logic [7:0] TGT [8] = '{8'h18, 8'h1B, 8'h1E, 8'h21,
                                     8'h24, 8'h26, 8'h28, 8'h2A};
  localparam logic [7:0] THR [4] = '{8'h00, 8'h06, 8'h0A, 8'h0E};

  agc_gain_limit_config uut (
    .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .csn(csn), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .filt_amp(filt_amp),
    .amp_valid(amp_valid), .rssi(rssi), .rssi_valid(rssi_valid),
    .gain(gain), .carrier_sense(carrier_sense)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_gain(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_gain

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  // ----------------------------------------------------------------
  // port drivers
  // ----------------------------------------------------------------
  // one frame, msb first; read data is taken just before each data rise
  task automatic frame(input logic rw, input logic [5:0] a,
                       input logic [7:0] wd);
    logic [15:0] sh;
    sh = {rw, 1'b0, a, wd};
    @(posedge clk_sys) csn <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys) mosi <= sh[i];
      sclk <= 1'b0;
      repeat (3) @(posedge clk_sys);
      if (i < 8) rd[i] = miso;
      sclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys) sclk <= 1'b0;
    repeat (3) @(posedge clk_sys);
    csn <= 1'b1;
    repeat (12) @(posedge clk_sys);
  endtask : frame

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    frame(1'b0, a, d);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    frame(1'b1, a, 8'h00);
    cmp_reg(rd, exp);
  endtask : rd_chk

  task automatic pulse_amp(input logic [7:0] v);
    @(posedge clk_sys) filt_amp <= v;
    amp_valid <= 1'b1;
    @(posedge clk_sys) amp_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse_amp

  task automatic pulse_rssi(input logic [7:0] v);
    @(posedge clk_sys) rssi <= v;
    rssi_valid <= 1'b1;
    @(posedge clk_sys) rssi_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse_rssi

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic check_reset();
    cmp_gain(gain, 9'h000);
    cmp_bit(carrier_sense, 1'b0);
    cmp_bit(miso_oe, 1'b0);
    rd_chk(6'h1B, 8'h03);
    rd_chk(6'h1C, 8'h40);
  endtask : check_reset

  task automatic check_regs();
    wr(6'h1B, 8'hC5);
    rd_chk(6'h1B, 8'hC5);
    wr(6'h1C, 8'hFF);
    rd_chk(6'h1C, 8'h70);
    rd_chk(6'h20, 8'h00);
    wr(6'h1B, 8'h03);
    wr(6'h1C, 8'h40);
  endtask : check_regs

  task automatic check_dig_ceiling();
    for (int k = 0; k < 4; k++) begin
      wr(6'h1B, {2'(k), 6'h03});
      repeat (10) pulse_amp(8'h00);
      cmp_gain(gain, {3'(7 - k), 6'h00});
    end
  endtask : check_dig_ceiling

  task automatic check_fe_ceiling();
    for (int n = 1; n < 8; n++) begin
      wr(6'h1B, {2'h0, 3'(n), 3'h3});
      cmp_reg(8'(gain.stage1_red) + 8'(gain.stage2_red), 8'(n));
    end
    wr(6'h1B, 8'h03);
    repeat (20) pulse_amp(8'h00);
    cmp_gain(gain, 9'h1C0);
  endtask : check_fe_ceiling

  task automatic check_order();
    repeat (8) pulse_amp(8'hFF);
    cmp_gain(gain, 9'h008);
    pulse_amp(8'h00);
    cmp_gain(gain, 9'h000);
    wr(6'h1C, 8'h00);
    pulse_amp(8'hFF);
    cmp_gain(gain, 9'h001);
    repeat (7) pulse_amp(8'hFF);
    cmp_gain(gain, 9'h00F);
    pulse_amp(8'h00);
    cmp_gain(gain, 9'h007);
    repeat (6) pulse_amp(8'h00);
    cmp_gain(gain, 9'h001);
    wr(6'h1C, 8'h40);
  endtask : check_order

  task automatic check_setpoint();
    repeat (5) pulse_amp(8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(6'h1B, {5'h00, 3'(c)});
      pulse_amp(TGT[c]);
      cmp_gain(gain, 9'h100);
      pulse_amp(TGT[c] + 8'h01);
      cmp_gain(gain, 9'h0C0);
      pulse_amp(TGT[c] - 8'h01);
      cmp_gain(gain, 9'h100);
    end
  endtask : check_setpoint

  task automatic check_carrier();
    pulse_rssi(8'h00);
    pulse_rssi(8'h64);
    cmp_bit(carrier_sense, 1'b0);
    for (int c = 1; c < 4; c++) begin
      wr(6'h1C, {2'h1, 2'(c), 4'h0});
      pulse_rssi(8'h32);
      pulse_rssi(8'h31 + THR[c]);
      cmp_bit(carrier_sense, 1'b0);
      pulse_rssi(8'h32 + THR[c]);
      cmp_bit(carrier_sense, 1'b1);
      wr(6'h1C, 8'h40);
      cmp_bit(carrier_sense, 1'b0);
    end
  endtask : check_carrier

  // reset in mid-run must bring every field back to its reset value
  task automatic check_mid_reset();
    wr(6'h1B, 8'hFF);
    @(posedge clk_sys) rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_reset();
  endtask : check_mid_reset

  initial begin
    rstn = 1'b0;
    sclk = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
    filt_amp = 8'h00;
    amp_valid = 1'b0;
    rssi = 8'h00;
    rssi_valid = 1'b0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_reset();
    check_regs();
    check_dig_ceiling();
    check_fe_ceiling();
    check_order();
    check_setpoint();
    check_carrier();
    check_mid_reset();
    end_sim();
  end

  // cuts a hang short
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    end_sim();
  end
endmodule : test_agc_gain_limit_config
